// >>> design/ppm_pin_remap_matrix.sv
/*
 * Peripheral pin remap matrix: per-peripheral input selection, per-pin output
 * selection, map lock with key sequence, and shadow monitoring of the map.
 * Assumes peripherals and port logic run on clk_i and pins are asynchronous.
 */
// The Wishbone interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
module ppm_pin_remap_matrix
#(
   parameter int NUM_PINS = ppm_pkg::NUM_PINS_DEF
)
(
   // Clock and reset
   input  wire logic                          clk_i,
   input  wire logic                          resetn_i,
   // Wishbone slave
   input  wire logic                          wb_cyc_i,
   input  wire logic                          wb_stb_i,
   input  wire logic                          wb_we_i,
   input  wire logic [ppm_pkg::ADR_W-1:0]     wb_adr_i,
   input  wire logic [3:0]                    wb_sel_i,
   input  wire logic [31:0]                   wb_dat_i,
   output logic      [31:0]                   wb_dat_o,
   output logic                               wb_ack_o,
   // Remappable pins
   input  wire logic [NUM_PINS-1:0]           pin_in_i,
   input  wire logic [NUM_PINS-1:0]           pin_analog_i,
   output logic      [NUM_PINS-1:0]           pin_out_o,
   output logic      [NUM_PINS-1:0]           pin_oe_n_o,
   // Port and fixed functions on the pins
   input  wire logic [NUM_PINS-1:0]           port_out_i,
   input  wire logic [NUM_PINS-1:0]           pin_direction_bit_i,
   input  wire logic [NUM_PINS-1:0]           special_en_i,
   input  wire logic [NUM_PINS-1:0]           special_out_i,
   input  wire logic [NUM_PINS-1:0]           special_oe_n_i,
   // Peripherals
   input  wire ppm_pkg::ppm_periph_out_t      periph_out_i,
   output ppm_pkg::ppm_periph_in_t            periph_in_o,
   // Status
   output logic                               map_lock_o,
   output logic                               cfg_mismatch_o
);
   import ppm_pkg::*;

   // ==========================================================================
   // Storage
   // one field each
   logic [SEL_W-1:0]    in_sel     [NUM_IN];
   logic [SEL_W-1:0]    in_shadow  [NUM_IN];
   logic [SEL_W-1:0]    out_sel    [NUM_PINS];
   logic [SEL_W-1:0]    out_shadow [NUM_PINS];
   logic [NUM_PINS-1:0] pin_meta;
   logic [NUM_PINS-1:0] pin_sync;
   logic [NUM_IN-1:0]   next_in;
   logic [NUM_PINS-1:0] next_out;
   logic [NUM_PINS-1:0] next_oe_n;
   logic [31:0]         next_rdata;
   logic [31:0]         code_vec;
   ppm_seq_t            seq;
   logic                lock;
   logic                req;
   logic                wr;
   logic                osc_wr;
   logic [IDX_W-1:0]    widx;

   // Maps each output function code onto its bit position.
   // excluded functions absent
   function automatic logic [31:0] codes(input ppm_periph_out_t o);
      logic [31:0] v;
      v = '0;
      v[CODE_CMP1 +: 2] = o.comparator_output[1:0];
      v[CODE_UART1_TRANSMIT +: 4] = {o.uart2_request_to_send, o.uart2_transmit,
                           o.uart1_request_to_send, o.uart1_transmit};
      v[CODE_S1DO +: 6] = {o.serial2_out, o.serial1_out};
      v[CODE_OC1 +: 5]  = o.compare_output;
      v[CODE_CTP]       = o.charge_time_pulse;
      v[CODE_CMP3]      = o.comparator_output[2];
      return v;
   endfunction

   assign req      = wb_cyc_i & wb_stb_i;
   assign widx     = wb_adr_i[ADR_W-1:2];
   // Writes land on the same edge at which the master sees ack.
   assign wr       = req & wb_we_i & wb_ack_o;
   assign osc_wr   = wr & (widx == OSC_IDX) & wb_sel_i[0];
   assign code_vec = codes(periph_out_i);
   assign map_lock_o = lock;

   // ==========================================================================
   // Bus answer
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end
      else
      begin
         wb_ack_o <= req & ~wb_ack_o;
         wb_dat_o <= next_rdata;
      end
   end

   // Unmapped words read as zero and ignore writes.
   always_comb
   begin
      next_rdata = '0;
      for (int i = 0; i < NUM_IN; i++)
      begin
         if (widx == IN_REG[i] && IN_HI[i])
            next_rdata[HI_LSB +: SEL_W] = in_sel[i];
         else if (widx == IN_REG[i])
            next_rdata[LO_LSB +: SEL_W] = in_sel[i];
      end
      for (int p = 0; p < NUM_PINS; p++)
      begin
         if (widx == IDX_W'(OUT_BASE + p / 2) && (p % 2) == 1)
            next_rdata[HI_LSB +: SEL_W] = out_sel[p];
         else if (widx == IDX_W'(OUT_BASE + p / 2))
            next_rdata[LO_LSB +: SEL_W] = out_sel[p];
      end
      if (widx == OSC_IDX)
         next_rdata[LOCK_BIT] = lock;
   end

   // ==========================================================================
   // Map registers and shadow copy
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         for (int i = 0; i < NUM_IN; i++)
         begin
            in_sel[i]    <= IN_RST;
            in_shadow[i] <= IN_RST;
         end
         for (int p = 0; p < NUM_PINS; p++)
         begin
            out_sel[p]    <= OUT_RST;
            out_shadow[p] <= OUT_RST;
         end
      end
      else if (wr && !lock)
      begin
         for (int i = 0; i < NUM_IN; i++)
         begin
            if (widx == IN_REG[i] && IN_HI[i] && wb_sel_i[1])
            begin
               in_sel[i]    <= wb_dat_i[HI_LSB +: SEL_W];
               in_shadow[i] <= wb_dat_i[HI_LSB +: SEL_W];
            end
            else if (widx == IN_REG[i] && !IN_HI[i] && wb_sel_i[0])
            begin
               in_sel[i]    <= wb_dat_i[LO_LSB +: SEL_W];
               in_shadow[i] <= wb_dat_i[LO_LSB +: SEL_W];
            end
         end
         for (int p = 0; p < NUM_PINS; p++)
         begin
            if (widx == IDX_W'(OUT_BASE + p / 2) && (p % 2) == 1 && wb_sel_i[1])
            begin
               out_sel[p]    <= wb_dat_i[HI_LSB +: SEL_W];
               out_shadow[p] <= wb_dat_i[HI_LSB +: SEL_W];
            end
            else if (widx == IDX_W'(OUT_BASE + p / 2) && (p % 2) == 0 && wb_sel_i[0])
            begin
               out_sel[p]    <= wb_dat_i[LO_LSB +: SEL_W];
               out_shadow[p] <= wb_dat_i[LO_LSB +: SEL_W];
            end
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
         cfg_mismatch_o <= 1'b0;
      else
         cfg_mismatch_o <= (in_sel != in_shadow) || (out_sel != out_shadow);
   end

   // ==========================================================================
   // Lock key sequence
   // key sequence tracking
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
         seq <= SEQ_IDLE;
      else if (wr)
      begin
         case (seq)
            SEQ_IDLE: seq <= (osc_wr && wb_dat_i[7:0] == KEY1) ? SEQ_KEY1 : SEQ_IDLE;
            SEQ_KEY1: seq <= (osc_wr && wb_dat_i[7:0] == KEY2) ? SEQ_OPEN : SEQ_IDLE;
            default:  seq <= SEQ_IDLE;
         endcase
      end
   end

   // The lock resets open so the map can be set up without keys.
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
         lock <= 1'b0;
      else if (osc_wr && seq == SEQ_OPEN)
         lock <= wb_dat_i[LOCK_BIT];
   end

   // ==========================================================================
   // Input routing
   // fixed remappable pins
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         pin_meta <= '0;
         pin_sync <= '0;
      end
      else
      begin
         pin_meta <= pin_in_i;
         pin_sync <= pin_meta;
      end
   end

   always_comb
   begin
      next_in = '0;
      for (int i = 0; i < NUM_IN; i++)
      begin
         if (int'(in_sel[i]) < NUM_PINS)
            next_in[i] = pin_sync[in_sel[i]] & ~pin_analog_i[in_sel[i]];
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
         periph_in_o <= '0;
      else
         periph_in_o <= ppm_periph_in_t'(next_in);
   end

   // ==========================================================================
   // Output routing
   always_comb
   begin
      for (int p = 0; p < NUM_PINS; p++)
      begin
         if (special_en_i[p])
         begin
            next_out[p]  = special_out_i[p];
            next_oe_n[p] = special_oe_n_i[p];
         end
         else if (OUT_VALID[out_sel[p]])
         begin
            next_out[p]  = code_vec[out_sel[p]];
            next_oe_n[p] = 1'b0;
         end
         // null and unused codes fall to port; direction bit rules
         else
         begin
            next_out[p]  = port_out_i[p];
            next_oe_n[p] = pin_direction_bit_i[p];
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         pin_out_o  <= '0;
         pin_oe_n_o <= '1;
      end
      else
      begin
         pin_out_o  <= next_out;
         pin_oe_n_o <= next_oe_n;
      end
   end

   // ==========================================================================
   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   a_lock_blocks_map: assert property (wr && lock && widx != OSC_IDX |=>
      $stable(in_sel[0]) && $stable(out_sel[0]) && $stable(out_sel[1]))
      else $error("map changed while locked");
   a_reset_codes: assert property (disable iff (1'b0) !resetn_i |=>
      in_sel[0] == IN_RST && out_sel[0] == OUT_RST)
      else $error("map reset value wrong");
   a_null_port: assert property (out_sel[0] == OUT_RST && !special_en_i[0] |=>
      pin_out_o[0] == $past(port_out_i[0]) && pin_oe_n_o[0] == $past(pin_direction_bit_i[0]))
      else $error("null code not under port");
   a_remap_wins: assert property (OUT_VALID[out_sel[0]] && !special_en_i[0] |=>
      pin_out_o[0] == $past(code_vec[out_sel[0]]) && !pin_oe_n_o[0])
      else $error("remapped output lost");
   a_special_wins: assert property (special_en_i[0] |=>
      pin_out_o[0] == $past(special_out_i[0]) && pin_oe_n_o[0] == $past(special_oe_n_i[0]))
      else $error("special output lost");
   a_unused_port: assert property (!OUT_VALID[out_sel[0]] && !special_en_i[0] |=>
      pin_oe_n_o[0] == $past(pin_direction_bit_i[0]))
      else $error("unused code drove pin");
   a_unimpl_low: assert property (int'(in_sel[0]) >= NUM_PINS |=>
      !periph_in_o.ext_interrupt_one)
      else $error("missing pin not low");
   a_analog_gate: assert property (int'(in_sel[1]) < NUM_PINS && pin_analog_i[in_sel[1]] |=>
      !periph_in_o.ext_interrupt_two)
      else $error("analog pin passed input");
   a_pin_route: assert property (int'(in_sel[1]) < NUM_PINS && !pin_analog_i[in_sel[1]] |=>
      periph_in_o.ext_interrupt_two == $past(pin_sync[in_sel[1]]))
      else $error("input routed wrong");
   a_shadow_quiet: assert property (!wr ##1 !wr |=> !cfg_mismatch_o)
      else $error("shadow mismatch");
   a_key_order: assert property ($changed(lock) |-> $past(seq) == SEQ_OPEN)
      else $error("lock changed without keys");

   c_lock_set:   cover property ($rose(lock));
   c_unlocked_w: cover property (wr && !lock && widx == OUT_BASE);
   c_remap_pin:  cover property (OUT_VALID[out_sel[0]] && !special_en_i[0]);
   c_analog_in:  cover property (int'(in_sel[1]) < NUM_PINS && pin_analog_i[in_sel[1]]);

endmodule

// >>> design/ppm_pkg.sv
/*
 * Shared constants and carriers of the pin remap matrix: register word indices,
 * field positions, reset codes, output function codes and the peripheral structs.
 * Assumes a Wishbone slave with a 32-bit data bus and byte addresses.
 */
package ppm_pkg;

   // ==========================================================================
   // Sizes
   localparam int SEL_W        = 5;
   localparam int NUM_PINS_DEF = 25;
   localparam int NUM_IN       = 23;
   localparam int ADR_W        = 8;
   localparam int IDX_W        = 6;

   // ==========================================================================
   // Register word indices; byte address is four times the index
   localparam logic [IDX_W-1:0] OUT_BASE = 6'h20;
   localparam logic [IDX_W-1:0] OSC_IDX  = 6'h30;
   localparam logic [IDX_W-1:0] IN_REG [NUM_IN] = '{
      6'h00, 6'h01, 6'h03, 6'h03, 6'h04, 6'h04, 6'h07, 6'h07, 6'h08, 6'h08, 6'h09, 6'h0B,
      6'h0B, 6'h12, 6'h12, 6'h13, 6'h13, 6'h14, 6'h14, 6'h15, 6'h16, 6'h16, 6'h17};
   // A set bit puts that input field in the upper byte lane of its register.
   localparam logic [NUM_IN-1:0] IN_HI = 23'h2552A9;

   // ==========================================================================
   // Field layout and reset values
   localparam int LO_LSB   = 0;
   localparam int HI_LSB   = 8;
   localparam int LOCK_BIT = 6;
   localparam logic [SEL_W-1:0] IN_RST  = 5'h1F;
   localparam logic [SEL_W-1:0] OUT_RST = 5'h00;
   localparam logic [7:0]       KEY1    = 8'h46;
   localparam logic [7:0]       KEY2    = 8'h57;

   // ==========================================================================
   // Output function codes
   localparam int CODE_CMP1 = 1;
   localparam int CODE_UART1_TRANSMIT = 3;
   localparam int CODE_S1DO = 7;
   localparam int CODE_OC1  = 18;
   localparam int CODE_CTP  = 29;
   localparam int CODE_CMP3 = 30;
   localparam logic [31:0] OUT_VALID = 32'h607C1FFE;

   // ==========================================================================
   // Carriers; the last member is bit 0
   typedef struct packed {
      logic serial2_select_in;
      logic serial2_clock_in;
      logic serial2_data_in;
      logic serial1_select_in;
      logic serial1_clock_in;
      logic serial1_data_in;
      logic uart2_clear_to_send;
      logic uart2_receive;
      logic uart1_clear_to_send;
      logic uart1_receive;
      logic compare_fault_b;
      logic compare_fault_a;
      logic capture_input_five;
      logic capture_input_four;
      logic capture_input_three;
      logic capture_input_two;
      logic capture_input_one;
      logic timer5_ext_clock;
      logic timer4_ext_clock;
      logic timer3_ext_clock;
      logic timer2_ext_clock;
      logic ext_interrupt_two;
      logic ext_interrupt_one;
   } ppm_periph_in_t;

   typedef struct packed {
      logic [4:0] compare_output;
      logic       charge_time_pulse;
      logic [2:0] comparator_output;
      logic       uart1_transmit;
      logic       uart1_request_to_send;
      logic       uart2_transmit;
      logic       uart2_request_to_send;
      logic [2:0] serial1_out;
      logic [2:0] serial2_out;
   } ppm_periph_out_t;

   typedef enum logic [2:0] {
      SEQ_IDLE = 3'b001,
      SEQ_KEY1 = 3'b010,
      SEQ_OPEN = 3'b100
   } ppm_seq_t;

endpackage

// >>> dv/ppm_far_model.sv
/*
 * Far side of the remap matrix: the pin pads and the peripherals behind it.
 * Assumes the bench sets the wanted levels; they reach the block one edge later.
 */
`timescale 1ns/1ps
module ppm_far_model
(
   // Clock
   input  wire logic                 clk_i,
   // Wanted levels
   input  wire logic [24:0]          pin_lvl_i,
   input  wire logic [18:0]          out_lvl_i,
   // Driven into the block
   output logic      [24:0]          pin_in_o,
   output ppm_pkg::ppm_periph_out_t  periph_out_o
);
   import ppm_pkg::*;

   // ==========================================================================
   // Pads and peripherals
   // Registered so the block always sees levels that change just after an edge.
   always_ff @(posedge clk_i)
   begin
      pin_in_o     <= pin_lvl_i;
      periph_out_o <= out_lvl_i;
   end
endmodule

// >>> dv/ppm_pin_remap_matrix_tb.sv
/*
 * Self-checking bench of the pin remap matrix: register bus, pin paths and lock.
 * Assumes the far model feeds pins and peripherals; clock 10 MHz.
 */
`timescale 1ns/1ps
module ppm_pin_remap_matrix_tb;
   import ppm_pkg::*;

   logic            clk_i;
   logic            resetn_i;
   logic            cyc, stb, we, ack, lock, mism;
   logic [7:0]      adr;
   logic [3:0]      sel;
   logic [31:0]     wdat, rdat, r;
   logic [24:0]     pin_lvl, pin_in, analog, pin_out, oe_n, port_out, dir, sp_en, sp_out, sp_oe_n;
   logic [18:0]     out_lvl;
   ppm_periph_out_t periph_out;
   ppm_periph_in_t  periph_in;
   int              n_errors, check_count;

   ppm_far_model far (.clk_i(clk_i), .pin_lvl_i(pin_lvl), .out_lvl_i(out_lvl), .pin_in_o(pin_in),
      .periph_out_o(periph_out));
   ppm_pin_remap_matrix dut (.clk_i(clk_i), .resetn_i(resetn_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .pin_in_i(pin_in), .pin_analog_i(analog), .pin_out_o(pin_out), .pin_oe_n_o(oe_n),
      .port_out_i(port_out), .pin_direction_bit_i(dir), .special_en_i(sp_en), .special_out_i(sp_out),
      .special_oe_n_i(sp_oe_n), .periph_out_i(periph_out), .periph_in_o(periph_in), .map_lock_o(lock),
      .cfg_mismatch_o(mism));

   // ==========================================================================
   // Shared tasks
   task automatic finish_test();
      $display("Checks %0d, mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
         n_errors++;
      end
   endtask

   // Entered just after a rising edge; the request stands until ack is sampled.
   task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      wdat <= d;
      do
      begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (n >= 20)
      begin
         n_errors++;
         finish_test();
      end
      r = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, 4'hF, d);
   endtask

   task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, 4'hF, 32'h0);
      check(r, exp);
   endtask

   // Software keys the oscillator word before changing the lock.
   // key sequence
   task automatic lock_seq(input logic [7:0] v);
      wr(8'hC0, 32'h46);
      wr(8'hC0, 32'h57);
      wr(8'hC0, {24'h0, v});
   endtask

   task automatic settle();
      repeat (6) @(posedge clk_i);
   endtask

   function automatic int src_bit(input int c);
      case (c)
         1, 2: return c + 9;
         3, 4, 5, 6: return 12 - c;
         7, 8, 9, 18, 19, 20, 21, 22: return c - 4;
         10, 11, 12: return c - 10;
         29: return 13;
         30: return 12;
         default: return -1;
      endcase
   endfunction

   // ==========================================================================
   // Scenarios
   task automatic t_reset();
      chk_rd(8'h00, 32'h1F00);
      chk_rd(8'h04, 32'h001F);
      chk_rd(8'h80, 32'h0);
      check(32'(oe_n), 32'h1FFFFFF);
      check(32'(periph_in), 32'h0);
      check(32'(lock), 32'h0);
      $display("Test reset done");
   endtask

   // Peripherals get a pin only once software maps them.
   // map before use
   task automatic t_input();
      wr(8'h48, 32'h1E04);
      wr(8'h04, 32'h0004);
      chk_rd(8'h48, 32'h1E04);
      chk_rd(8'h04, 32'h0004);
      pin_lvl <= '1;
      settle();
      check(32'(periph_in.uart1_receive), 32'h1);
      check(32'(periph_in.ext_interrupt_two), 32'h1);
      check(32'(periph_in.uart1_clear_to_send), 32'h0);
      check(32'(periph_in.ext_interrupt_one), 32'h0);
      check(32'(oe_n[4]), 32'h1);
      pin_lvl[4] <= 1'b0;
      settle();
      check(32'(periph_in.uart1_receive), 32'h0);
      pin_lvl[4] <= 1'b1;
      analog[4] <= 1'b1;
      settle();
      check(32'(periph_in.uart1_receive), 32'h0);
      check(32'(periph_in.ext_interrupt_two), 32'h0);
      analog[4] <= 1'b0;
      wb(1'b1, 8'h48, 4'h1, 32'h1F1F);
      chk_rd(8'h48, 32'h1E1F);
      $display("Test input done");
   endtask

   task automatic t_output();
      int b;
      for (int c = 0; c < 32; c++)
      begin
         wr(8'h80, 32'(c));
         b = src_bit(c);
         out_lvl <= (b < 0) ? '1 : 19'(1) << b;
         settle();
         check({pin_out[0], oe_n[0]}, (b < 0) ? 32'h3 : 32'h2);
         if (b >= 0)
         begin
            out_lvl <= ~(19'(1) << b);
            settle();
            check({pin_out[0], oe_n[0]}, 32'h0);
         end
      end
      wr(8'h80, 32'h0300);
      out_lvl <= 19'h00200;
      port_out[0] <= 1'b0;
      settle();
      check({pin_out[1], pin_out[0]}, 32'h2);
      sp_en[1:0] <= 2'b11;
      settle();
      check({pin_out[1], oe_n[1]}, 32'h1);
      check({pin_out[0], oe_n[0]}, 32'h1);
      sp_en[1:0] <= 2'b00;
      port_out[0] <= 1'b1;
      $display("Test output done");
   endtask

   task automatic t_lock();
      wr(8'h80, 32'h0005);
      lock_seq(8'h40);
      check(32'(lock), 32'h1);
      chk_rd(8'hC0, 32'h40);
      wr(8'h80, 32'h0007);
      chk_rd(8'h80, 32'h0005);
      wr(8'hC0, 32'h46);
      wr(8'h84, 32'h0);
      wr(8'hC0, 32'h57);
      wr(8'hC0, 32'h0);
      check(32'(lock), 32'h1);
      lock_seq(8'h00);
      check(32'(lock), 32'h0);
      wr(8'h80, 32'h0007);
      chk_rd(8'h80, 32'h0007);
      wr(8'hFC, 32'hFFFF);
      chk_rd(8'hFC, 32'h0);
      check(32'(mism), 32'h0);
      $display("Test lock done");
   endtask

   // ==========================================================================
   // Clock, reset and main sequence
   initial
   begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end

   initial
   begin
      n_errors = 0;
      check_count = 0;
      resetn_i = 1'b0;
      {cyc, stb, we} = 3'b000;
      adr = 8'h00;
      sel = 4'h0;
      wdat = 32'h0;
      pin_lvl = '0;
      out_lvl = '0;
      analog = '0;
      port_out = '1;
      dir = '1;
      sp_en = '0;
      sp_out = '0;
      sp_oe_n = '1;
      repeat (16) @(posedge clk_i);
      resetn_i <= 1'b1;
      @(posedge clk_i);
      t_reset();
      t_input();
      t_output();
      t_lock();
      finish_test();
   end
endmodule
